/* File: design/irs_pkg.sv */
// Constants and types shared by the register read slave
package irs_pkg;
  // ----------------------------------------
  // Addressing and opcodes
  // ----------------------------------------
  localparam logic [6:0]  SLAVE_BASE = 7'h68;
  localparam logic [2:0]  OP_READ    = 3'h4;
  localparam logic [2:0]  OP_WRITE   = 3'h3;
  localparam logic [4:0]  PORT_REGS  = 5'h00;
  localparam logic [11:0] OFS_SUBSYS = 12'h0F8;
  localparam logic [11:0] OFS_EVENTS = 12'h0F0;
  // ----------------------------------------
  // Command field positions
  // ----------------------------------------
  localparam int B2_PORT0  = 7;
  localparam int B2_BE_LSB = 2;
  // ----------------------------------------
  // Event register field positions
  // ----------------------------------------
  localparam int W1C_LSB  = 0;
  localparam int SW1C_LSB = 8;
  localparam int SRW_LSB  = 16;
  localparam int HWI_LSB  = 24;
  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [31:0] RST_SUBSYS = 32'h00000000;
  localparam logic [7:0]  RST_FIELD  = 8'h00;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam logic [3:0]  CMD_LAST   = 4'h3;
  localparam logic [3:0]  WR_LAST    = 4'h7;
  localparam logic [3:0]  IDX_SAT    = 4'h8;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]  opcode;
    logic [4:0]  port;
    logic [3:0]  byteEn;
    logic [11:0] regAddr;
  } irs_cmd_t;
  typedef struct packed {
    logic        stb;
    logic [4:0]  port;
    logic [3:0]  byteEn;
    logic [11:0] regAddr;
    logic [31:0] data;
  } irs_wr_t;
  typedef struct packed {
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
    logic sda;
  } irs_bus_t;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_RX     = 5'h02,
    ST_RX_ACK = 5'h04,
    ST_TX     = 5'h08,
    ST_TX_ACK = 5'h10
  } irs_state_t;
endpackage

/* File: design/irs_bus_events.sv */
// Edge, START and STOP detection on the sampled bus lines
`timescale 1ns/1ps
module irs_bus_events (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output irs_pkg::irs_bus_t      ev
);
  import irs_pkg::*;
  logic sclPrev;
  logic sdaPrev;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclIn;
      sdaPrev <= sdaIn;
    end
  end
  assign ev.sclRise = ~sclPrev & sclIn;
  assign ev.sclFall = sclPrev & ~sclIn;
  assign ev.start   = sclPrev & sclIn & sdaPrev & ~sdaIn;
  assign ev.stop    = sclPrev & sclIn & ~sdaPrev & sdaIn;
  assign ev.sda     = sdaIn;
endmodule

/* File: design/irs_cfg_regs.sv */
// Configuration registers reachable through the serial port
`timescale 1ns/1ps
module irs_cfg_regs (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              hotResetn,
  input  wire logic [7:0]        hwEvent,
  input  wire logic [7:0]        stickyEvent,
  input  wire logic [7:0]        hwInitValue,
  input  wire logic [4:0]        rdPort,
  input  wire logic [11:0]       rdAddr,
  input  irs_pkg::irs_wr_t       wr,
  output logic [31:0]            rdData,
  output logic [7:0]             stickyCtrl
);
  import irs_pkg::*;
  function automatic logic [1:0] selOf(input logic [4:0] port, input logic [11:0] addr);
    if (port != PORT_REGS) selOf = 2'b00;
    else if (addr == OFS_SUBSYS) selOf = 2'b01;
    else if (addr == OFS_EVENTS) selOf = 2'b10;
    else selOf = 2'b00;
  endfunction
  logic [7:0] w1c;
  logic [7:0] sw1c;
  logic [7:0] hwInit;
  logic       initDone;
  wire  [1:0] rdSel     = selOf(rdPort, rdAddr);
  wire  [1:0] wrSel     = selOf(wr.port, wr.regAddr);
  wire        wrEv      = wr.stb & wrSel[1];
  wire  [7:0] clrW1c    = (wrEv & wr.byteEn[0]) ? wr.data[W1C_LSB +: 8] : 8'h00;
  wire  [7:0] clrSw1c   = (wrEv & wr.byteEn[1]) ? wr.data[SW1C_LSB +: 8] : 8'h00;
  wire  [7:0] next_w1c  = (w1c & ~clrW1c) | hwEvent;
  wire  [7:0] next_sw1c = (sw1c & ~clrSw1c) | stickyEvent;
  wire [31:0] evWord    = {hwInit, stickyCtrl, sw1c, w1c};
  // ----------------------------------------
  // Field storage
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) w1c <= RST_FIELD;
    else if (!hotResetn) w1c <= RST_FIELD;
    else w1c <= next_w1c;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) sw1c <= RST_FIELD;
    else sw1c <= next_sw1c;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) stickyCtrl <= RST_FIELD;
    else if (wrEv & wr.byteEn[2]) stickyCtrl <= wr.data[SRW_LSB +: 8];
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hwInit   <= RST_FIELD;
      initDone <= 1'b0;
    end else if (!initDone) begin
      hwInit   <= hwInitValue;
      initDone <= 1'b1;
    end
  end
  // ----------------------------------------
  // Registered read data
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) rdData <= 32'h00000000;
    else if (rdSel[0]) rdData <= RST_SUBSYS;
    else if (rdSel[1]) rdData <= evWord;
    else rdData <= 32'h00000000;
  end
endmodule

/* File: design/irs_top.sv */
// Serial slave port that fetches and returns configuration registers
//
// Behaviour
// - Command packet address byte is slave address with write bit; D0h by default.
// - Command byte 0 bits 2:0 equal 100b request a register fetch.
// - Command byte 2 bits 5:2 are four byte-lane enables.
// - Command byte 2 bits 1:0 give register address bits 11:10.
// - Command byte 3 gives register address bits 9:2.
// - Second packet uses read bit set, D1h by default, starting data return.
// - Data phase returns register byte 3, then 2, 1 and 0.
// - Slave address is 68h when the three address straps are zero.
// - Subsystem identifiers at F8h of port 0 read zero after reset.
// - Write-one-clear bits are readable; a one clears, a zero keeps.
// - Sticky write-one-clear bits survive the non-sticky reset.
// - Sticky read-write bits take writes and survive the non-sticky reset.
// - Hardware-initialized bits load from hardware, never from writes.
// - Reads past four bytes wrap back to buffer byte 3.
// - Repeated START may replace the STOP between the two packets.
// - Register address bits 1:0 are always zero.
`timescale 1ns/1ps
module irs_top (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        hotResetn,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  input  wire logic [2:0]  addrStrap,
  input  wire logic [7:0]  hwEvent,
  input  wire logic [7:0]  stickyEvent,
  input  wire logic [7:0]  hwInitValue,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic [7:0]       stickyCtrl
);
  import irs_pkg::*;
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  irs_bus_t   ev;
  irs_state_t state;
  irs_cmd_t   cmd;
  irs_wr_t    wr;
  logic [3:0]  bitCnt;
  logic [7:0]  shiftIn;
  logic [7:0]  txShift;
  logic [1:0]  txIdx;
  logic [3:0]  byteIdx;
  logic        addrPhase;
  logic        isRead;
  logic        masterAck;
  logic [31:0] wrData;
  logic [31:0] rdData;
  logic [31:0] readBuf;
  logic        fetchReq;
  logic        fetchPipe;
  logic        wrStb;
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [6:0] myAddr    = SLAVE_BASE | {4'h0, addrStrap};
  wire       addrHit   = shiftIn[7:1] == myAddr;
  wire       byteFull  = bitCnt == BYTE_BITS;
  wire       rxBit     = (state == ST_RX) && ev.sclRise;
  wire       rxDone    = (state == ST_RX) && ev.sclFall && byteFull;
  wire       ackEnd    = (state == ST_RX_ACK) && ev.sclFall;
  wire       txFall    = (state == ST_TX) && ev.sclFall;
  wire       txAckRise = (state == ST_TX_ACK) && ev.sclRise;
  wire       txAckFall = (state == ST_TX_ACK) && ev.sclFall;
  wire       ackNow    = addrPhase ? addrHit : 1'b1;
  wire       cmdDone   = rxDone && !addrPhase;
  wire       loadTx    = (ackEnd && isRead) || (txAckFall && masterAck);
  wire [7:0] txByte    = readBuf[{~txIdx, 3'h0} +: 8];
  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  irs_bus_events u_events (
    .core_clk (core_clk),
    .resetn   (resetn),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .ev       (ev)
  );
  irs_cfg_regs u_regs (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .hotResetn   (hotResetn),
    .hwEvent     (hwEvent),
    .stickyEvent (stickyEvent),
    .hwInitValue (hwInitValue),
    .rdPort      (cmd.port),
    .rdAddr      (cmd.regAddr),
    .wr          (wr),
    .rdData      (rdData),
    .stickyCtrl  (stickyCtrl)
  );
  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state  <= ST_IDLE;
      bitCnt <= 4'h0;
      sdaOe  <= 1'b0;
    end else if (ev.start) begin
      state  <= ST_RX;
      bitCnt <= 4'h0;
      sdaOe  <= 1'b0;
    end else if (ev.stop) begin
      state  <= ST_IDLE;
      bitCnt <= 4'h0;
      sdaOe  <= 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (rxBit) begin
            bitCnt <= bitCnt + 4'h1;
          end else if (rxDone) begin
            sdaOe <= ackNow;
            state <= ackNow ? ST_RX_ACK : ST_IDLE;
          end
        end
        ST_RX_ACK: begin
          if (ackEnd && isRead) begin
            sdaOe  <= ~txByte[7];
            bitCnt <= 4'h1;
            state  <= ST_TX;
          end else if (ackEnd) begin
            sdaOe  <= 1'b0;
            bitCnt <= 4'h0;
            state  <= ST_RX;
          end
        end
        ST_TX: begin
          if (txFall && byteFull) begin
            sdaOe <= 1'b0;
            state <= ST_TX_ACK;
          end else if (txFall) begin
            sdaOe  <= ~txShift[7];
            bitCnt <= bitCnt + 4'h1;
          end
        end
        ST_TX_ACK: begin
          if (txAckFall && masterAck) begin
            sdaOe  <= ~txByte[7];
            bitCnt <= 4'h1;
            state  <= ST_TX;
          end else if (txAckFall) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Shifters
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) shiftIn <= 8'h00;
    else if (rxBit) shiftIn <= {shiftIn[6:0], ev.sda};
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) txShift <= 8'h00;
    else if (loadTx) txShift <= {txByte[6:0], 1'b0};
    else if (txFall && !byteFull) txShift <= {txShift[6:0], 1'b0};
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) txIdx <= 2'h0;
    else if (rxDone && addrPhase) txIdx <= 2'h0;
    else if (txFall && byteFull) txIdx <= txIdx + 2'h1;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) masterAck <= 1'b0;
    else if (txAckRise) masterAck <= ~ev.sda;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) sdaOut <= 1'b0;
    else sdaOut <= 1'b0;
  end
  // ----------------------------------------
  // Packet position
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addrPhase <= 1'b1;
      isRead    <= 1'b0;
      byteIdx   <= 4'h0;
    end else if (ev.start) begin
      addrPhase <= 1'b1;
      byteIdx   <= 4'h0;
    end else if (rxDone && addrPhase) begin
      addrPhase <= 1'b0;
      isRead    <= shiftIn[0];
    end else if (cmdDone && byteIdx != IDX_SAT) begin
      byteIdx <= byteIdx + 4'h1;
    end
  end
  // ----------------------------------------
  // Command capture
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd <= '0;
    end else if (cmdDone) begin
      case (byteIdx)
        4'h0: begin
          cmd.opcode <= shiftIn[2:0];
        end
        4'h1: begin
          cmd.port[4:1] <= shiftIn[3:0];
        end
        4'h2: begin
          cmd.port[0]           <= shiftIn[B2_PORT0];
          cmd.byteEn            <= shiftIn[B2_BE_LSB +: 4];
          cmd.regAddr[11:10]    <= shiftIn[1:0];
        end
        4'h3: begin
          cmd.regAddr[9:2] <= shiftIn;
          cmd.regAddr[1:0] <= 2'h0;
        end
        default: begin
          cmd <= cmd;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) wrData <= 32'h00000000;
    else if (cmdDone && byteIdx > CMD_LAST) wrData <= {wrData[23:0], shiftIn};
  end
  // ----------------------------------------
  // Fetch into buffer and write request
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fetchReq  <= 1'b0;
      fetchPipe <= 1'b0;
    end else begin
      fetchReq  <= cmdDone && byteIdx == CMD_LAST && cmd.opcode == OP_READ;
      fetchPipe <= fetchReq;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) readBuf <= 32'h00000000;
    else if (fetchPipe) readBuf <= rdData;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) wrStb <= 1'b0;
    else wrStb <= cmdDone && byteIdx == WR_LAST && cmd.opcode == OP_WRITE;
  end
  assign wr.stb     = wrStb;
  assign wr.port    = cmd.port;
  assign wr.byteEn  = cmd.byteEn;
  assign wr.regAddr = cmd.regAddr;
  assign wr.data    = wrData;
endmodule

/* File: bench/irs_properties.sv */
// Concurrent checks on the ports of the register read slave
`timescale 1ns/1ps
module irs_properties (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       hotResetn,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic [2:0] addrStrap,
  input wire logic       sdaOe,
  input wire logic [7:0] stickyCtrl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic       sclQ;
  logic       sdaQ;
  logic       idle;
  logic [3:0] rises;
  logic [3:0] sinceFall;
  logic [7:0] addrSh;
  wire startEv = sclIn & sclQ & sdaQ & ~sdaIn;
  wire stopEv  = sclIn & sclQ & ~sdaQ & sdaIn;
  wire fallEv  = sclQ & ~sclIn;
  wire match   = addrSh[7:1] == (7'h68 | {4'h0, addrStrap});
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclQ      <= 1'b1;
      sdaQ      <= 1'b1;
      idle      <= 1'b1;
      rises     <= 4'h9;
      sinceFall <= 4'hF;
      addrSh    <= 8'h00;
    end else begin
      sclQ      <= sclIn;
      sdaQ      <= sdaIn;
      idle      <= stopEv | (idle & ~startEv);
      sinceFall <= fallEv ? 4'h1 : (sinceFall == 4'hF ? sinceFall : sinceFall + 4'h1);
      if (startEv) begin
        rises <= 4'h0;
      end else if (sclIn & ~sclQ & (rises != 4'h9)) begin
        rises  <= rises + 4'h1;
        addrSh <= (rises < 4'h8) ? {addrSh[6:0], sdaIn} : addrSh;
      end
    end
  end
  sequence ackSlot;
    (rises == 4'h8) && fallEv;
  endsequence
  sequence ackDrive;
    ##[1:4] sdaOe;
  endsequence
  a_addr_quiet: assert property (rises < 4'h8 |-> !sdaOe)
    else $error("SDA pulled during address bits");
  a_addr_ack: assert property (ackSlot ##0 match |-> ackDrive)
    else $error("matching address not acknowledged");
  a_foreign_quiet: assert property (rises >= 4'h8 && !match |-> !sdaOe)
    else $error("SDA pulled for a foreign address");
  a_idle_quiet: assert property (idle |-> !sdaOe)
    else $error("SDA pulled outside a frame");
  a_edge_timing: assert property ($changed(sdaOe) |-> sinceFall <= 4'h4)
    else $error("SDA changed late after SCL fall");
  a_stable_high: assert property (sclIn && sclQ |-> $stable(sdaOe))
    else $error("SDA changed while SCL high");
  a_sticky_hot: assert property (!hotResetn |=> $stable(stickyCtrl))
    else $error("sticky field lost on hot reset");
  a_ctrl_on_ack: assert property ($changed(stickyCtrl) |-> sdaOe && !sclIn)
    else $error("sticky field changed outside a write ack");
endmodule
bind irs_top irs_properties u_props (
  .core_clk   (core_clk),
  .resetn     (resetn),
  .hotResetn  (hotResetn),
  .sclIn      (sclIn),
  .sdaIn      (sdaIn),
  .addrStrap  (addrStrap),
  .sdaOe      (sdaOe),
  .stickyCtrl (stickyCtrl)
);

/* File: bench/irs_master.sv */
// Bus master model driving the serial lines of the slave port
`timescale 1ns/1ps
module irs_master (
  input  wire logic core_clk,
  input  wire logic sdaIn,
  output logic      sclOut,
  output logic      sdaDrv
);
  initial begin
    sclOut = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Opening of a frame, also a repeated start
  task automatic start();
    sdaDrv <= 1'b1;
    wt(6);
    sclOut <= 1'b1;
    wt(6);
    sdaDrv <= 1'b0;
    wt(6);
    sclOut <= 1'b0;
    wt(2);
  endtask
  task automatic stop();
    sdaDrv <= 1'b0;
    wt(6);
    sclOut <= 1'b1;
    wt(6);
    sdaDrv <= 1'b1;
    wt(6);
  endtask
  task automatic bitx(input logic b, output logic r);
    sdaDrv <= b;
    wt(6);
    sclOut <= 1'b1;
    wt(6);
    r = sdaIn;
    sclOut <= 1'b0;
    wt(2);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
endmodule

/* File: bench/tb.sv */
// Self-checking testbench for the register read slave
`timescale 1ns/1ps
module tb;
  import irs_pkg::*;
  logic       core_clk;
  logic       resetn;
  logic       hotResetn;
  logic [2:0] addrStrap;
  logic [7:0] hwEvent;
  logic [7:0] stickyEvent;
  logic [7:0] hwInitValue;
  logic [7:0] stickyCtrl;
  logic       sclIn;
  logic       sdaMst;
  logic       sdaOe;
  logic       sdaOut;
  wire        sdaIn = sdaMst & (sdaOe ? sdaOut : 1'b1);
  int         mismatches = 0;
  int         nCompared = 0;
  int         cycles = 0;
  irs_top u_dut (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .hotResetn   (hotResetn),
    .sclIn       (sclIn),
    .sdaIn       (sdaIn),
    .addrStrap   (addrStrap),
    .hwEvent     (hwEvent),
    .stickyEvent (stickyEvent),
    .hwInitValue (hwInitValue),
    .sdaOut      (sdaOut),
    .sdaOe       (sdaOe),
    .stickyCtrl  (stickyCtrl)
  );
  irs_master u_mst (
    .core_clk (core_clk),
    .sdaIn    (sdaIn),
    .sclOut   (sclIn),
    .sdaDrv   (sdaMst)
  );
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      testDone();
    end
  end
  task automatic testDone();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    nCompared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] a, input logic [31:0] c);
    logic ack;
    u_mst.start();
    u_mst.wr(a, ack);
    check(ack, 1'b1);
    for (int i = 3; i >= 0; i--) begin
      u_mst.wr(c[8*i+:8], ack);
      check(ack, 1'b1);
    end
  endtask
  task automatic rdw(input logic [7:0] a, input int n, output logic [47:0] q);
    logic       ack;
    logic [7:0] d;
    q = '0;
    u_mst.start();
    u_mst.wr(a, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_mst.rd(i == n - 1, d);
      q = {q[39:0], d};
    end
    u_mst.stop();
  endtask
  task automatic rdCmd(input logic [31:0] c, input logic [31:0] exp);
    logic [47:0] q;
    cmd(8'hD0, c);
    u_mst.stop();
    rdw(8'hD1, 4, q);
    check(q, {16'h0, exp});
  endtask
  task automatic wreg(input logic [7:0] b2, input logic [31:0] v);
    logic ack;
    cmd(8'hD0, {8'h03, 8'h00, b2, 8'h3C});
    for (int i = 3; i >= 0; i--) begin
      u_mst.wr(v[8*i+:8], ack);
      check(ack, 1'b1);
    end
    u_mst.stop();
  endtask
  task automatic t_events();
    logic [47:0] q;
    hwEvent     <= 8'hA5;
    stickyEvent <= 8'h3C;
    @(posedge core_clk);
    hwEvent     <= 8'h00;
    stickyEvent <= 8'h00;
    @(posedge core_clk);
    cmd(8'hD0, 32'h04003C3C);
    rdw(8'hD1, 6, q);
    check(q, 48'h5A003CA55A00);
    wreg(8'h3C, 32'hFF770C21);
    check(stickyCtrl, 8'h77);
    rdCmd(32'h04003C3C, 32'h5A773084);
    wreg(8'h10, 32'h0011FFFF);
    rdCmd(32'h04003C3C, 32'h5A113084);
  endtask
  task automatic t_subsys();
    rdCmd(32'h04003C3E, 32'h00000000);
    check(sdaOut, 1'b0);
  endtask
  task automatic t_hot();
    hotResetn <= 1'b0;
    @(posedge core_clk);
    hotResetn <= 1'b1;
    @(posedge core_clk);
    check(stickyCtrl, 8'h11);
    rdCmd(32'h04003C3C, 32'h5A113000);
  endtask
  task automatic t_select();
    logic [31:0] c [6] = '{32'hFC003C3C, 32'h04F03C3C, 32'h00003C3E,
                           32'h0400BC3C, 32'h04013C3C, 32'h04003D3C};
    logic [31:0] e [6] = '{32'h5A113000, 32'h5A113000, 32'h5A113000, 0, 0, 0};
    foreach (c[i]) begin
      rdCmd(c[i], e[i]);
    end
  endtask
  task automatic t_strap();
    logic        ack;
    logic [47:0] q;
    addrStrap <= 3'h5;
    @(posedge core_clk);
    u_mst.start();
    u_mst.wr(8'hD0, ack);
    check(ack, 1'b0);
    u_mst.stop();
    cmd(8'hDA, 32'h04003C3C);
    u_mst.stop();
    rdw(8'hDB, 4, q);
    check(q, 48'h5A113000);
    addrStrap <= 3'h0;
  endtask
  initial begin
    resetn      = 1'b0;
    hotResetn   = 1'b1;
    addrStrap   = 3'h0;
    hwEvent     = 8'h00;
    stickyEvent = 8'h00;
    hwInitValue = 8'h5A;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_events();
    t_subsys();
    t_hot();
    t_select();
    t_strap();
    testDone();
  end
endmodule
